// ===== input2_param_bank.sv
// input-two parameter bank, measurement path and first limit alarm
//
// Function
// - the correction-mode register picks none, offset, two-point correction or scaling for input two.
// - while the input reports a fault and forcing is off, the programmed substitute value replaces the measurement.
// - scaling maps the lower input point onto the lower display point.
// - scaling maps the upper input point onto the upper display point.
// - input two is low-pass filtered with a time constant in seconds from the filter register.
// - an external junction temperature is added when external compensation is selected.
// - the processed-value register is read-only and holds the corrected measurement.
// - the read-only fault register reports 0 no error, 1 break, 2 polarity, 4 short circuit.
// - the raw-value register is read-only and holds the unprocessed input sample.
// - a value written to the forcing register is taken as the measurement while forcing.
// - the limit-function register disables, monitors, or monitors with latching the first alarm.
// - a latched alarm holds until the error list or an error-reset input clears it.
// - the limit-source register selects the monitored quantity.
// - with the relative-deviation source the alarm is suppressed at start-up and setpoint changes.
// - the heating-current register selects no alarm, break, or break and short monitoring.
`timescale 1ns/1ns
module input2_param_bank #(
  parameter int SAMPLES_PER_SECOND = input2_bank_pkg::SAMPLES_PER_SECOND
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  input wire logic sample_valid,
  input wire logic signed [15:0] meas_raw,
  input wire logic [2:0] fault_in,
  input wire logic ext_comp_select,
  input wire logic force_enable,
  input wire logic signed [15:0] process_value,
  input wire logic signed [15:0] control_deviation,
  input wire logic signed [15:0] input1_value,
  input wire logic signed [15:0] effective_setpoint,
  input wire logic signed [15:0] controller_output,
  input wire logic suppress_relative,
  input wire logic signed [15:0] limit_low,
  input wire logic signed [15:0] limit_high,
  input wire logic error_list_clear,
  input wire logic error_reset_input,
  input wire logic heat_break,
  input wire logic heat_short,
  output logic signed [15:0] input2_value,
  output logic input2_valid,
  output logic limit_alarm,
  output logic [1:0] limit_status,
  output logic heat_alarm
);
  typedef struct packed {
    logic [15:0] correction_mode;
    logic [15:0] lower_input_point;
    logic [15:0] lower_display_point;
    logic [15:0] upper_input_point;
    logic [15:0] upper_display_point;
    logic [15:0] filter_time_constant;
    logic [15:0] junction_temperature;
    logic [15:0] fault_substitute;
    logic [15:0] processed_value;
    logic [15:0] fault_code;
    logic [15:0] raw_value;
    logic [15:0] forced_value;
    logic [15:0] heat_current_alarm_select;
    logic [15:0] limit1_function;
    logic [15:0] limit1_source;
    logic [15:0] stage;
    logic stage_valid;
    logic processed_valid;
    logic limit_latch;
    logic limit_alarm;
    logic [1:0] limit_status;
    logic heat_alarm;
    logic [15:0] rdata;
    logic ack;
  } bank_state_t;

  bank_state_t st;
  bank_state_t next_st;
  logic filt_valid;
  logic signed [15:0] filt_value;

  // --------------------------------------------------------------
  // arithmetic helpers
  // --------------------------------------------------------------
  function automatic logic [15:0] saturate(input logic signed [47:0] v);
    logic [15:0] r;
    r = v[15:0];
    if (v > 48'sd32767) begin
      r = 16'h7fff;
    end else if (v < -48'sd32768) begin
      r = 16'h8000;
    end
    return r;
  endfunction

  // two-point line through (in_l, out_l) and (in_h, out_h)
  function automatic logic [15:0] line_map(input logic signed [15:0] x, input logic signed [15:0] in_l,
                                           input logic signed [15:0] out_l, input logic signed [15:0] in_h,
                                           input logic signed [15:0] out_h);
    logic signed [47:0] den;
    logic signed [47:0] num;
    logic [15:0] r;
    den = 48'(in_h) - 48'(in_l);
    num = (48'(x) - 48'(in_l)) * (48'(out_h) - 48'(out_l));
    r = out_l;
    // a degenerate line would divide by zero, so it pins to the lower display point
    if (den != 48'sd0) begin
      r = saturate(48'(out_l) + num / den);
    end
    return r;
  endfunction

  // --------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------
  logic signed [15:0] source;
  logic signed [15:0] compensated;
  logic signed [15:0] corrected;
  logic exceed;
  logic clear;
  logic active;

  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.stage_valid = 1'b0;
    next_st.processed_valid = 1'b0;

    // register writes; read-only words have no write arm
    if (reg_write) begin
      next_st.ack = 1'b1;
      unique case (reg_addr)
        input2_bank_pkg::OFS_CORRECTION_MODE: next_st.correction_mode = reg_wdata;
        input2_bank_pkg::OFS_LOWER_INPUT_POINT: next_st.lower_input_point = reg_wdata;
        input2_bank_pkg::OFS_LOWER_DISPLAY_POINT: next_st.lower_display_point = reg_wdata;
        input2_bank_pkg::OFS_UPPER_INPUT_POINT: next_st.upper_input_point = reg_wdata;
        input2_bank_pkg::OFS_UPPER_DISPLAY_POINT: next_st.upper_display_point = reg_wdata;
        input2_bank_pkg::OFS_FILTER_TIME: next_st.filter_time_constant = reg_wdata;
        input2_bank_pkg::OFS_JUNCTION_TEMPERATURE: next_st.junction_temperature = reg_wdata;
        input2_bank_pkg::OFS_FAULT_SUBSTITUTE: next_st.fault_substitute = reg_wdata;
        input2_bank_pkg::OFS_FORCED_VALUE: next_st.forced_value = reg_wdata;
        input2_bank_pkg::OFS_HEAT_CURRENT_ALARM: next_st.heat_current_alarm_select = reg_wdata;
        input2_bank_pkg::OFS_LIMIT1_FUNCTION: next_st.limit1_function = reg_wdata;
        input2_bank_pkg::OFS_LIMIT1_SOURCE: next_st.limit1_source = reg_wdata;
        default: next_st.ack = 1'b1;
      endcase
    end else if (reg_read) begin
      next_st.ack = 1'b1;
      unique case (reg_addr)
        input2_bank_pkg::OFS_CORRECTION_MODE: next_st.rdata = st.correction_mode;
        input2_bank_pkg::OFS_LOWER_INPUT_POINT: next_st.rdata = st.lower_input_point;
        input2_bank_pkg::OFS_LOWER_DISPLAY_POINT: next_st.rdata = st.lower_display_point;
        input2_bank_pkg::OFS_UPPER_INPUT_POINT: next_st.rdata = st.upper_input_point;
        input2_bank_pkg::OFS_UPPER_DISPLAY_POINT: next_st.rdata = st.upper_display_point;
        input2_bank_pkg::OFS_FILTER_TIME: next_st.rdata = st.filter_time_constant;
        input2_bank_pkg::OFS_JUNCTION_TEMPERATURE: next_st.rdata = st.junction_temperature;
        input2_bank_pkg::OFS_FAULT_SUBSTITUTE: next_st.rdata = st.fault_substitute;
        input2_bank_pkg::OFS_PROCESSED_VALUE: next_st.rdata = st.processed_value;
        input2_bank_pkg::OFS_FAULT_CODE: next_st.rdata = st.fault_code;
        input2_bank_pkg::OFS_RAW_VALUE: next_st.rdata = st.raw_value;
        input2_bank_pkg::OFS_FORCED_VALUE: next_st.rdata = st.forced_value;
        input2_bank_pkg::OFS_HEAT_CURRENT_ALARM: next_st.rdata = st.heat_current_alarm_select;
        input2_bank_pkg::OFS_LIMIT1_FUNCTION: next_st.rdata = st.limit1_function;
        input2_bank_pkg::OFS_LIMIT1_SOURCE: next_st.rdata = st.limit1_source;
        default: next_st.rdata = input2_bank_pkg::RESET_VALUE;
      endcase
    end

    // measurement path: force, compensate, correct
    compensated = force_enable ? signed'(st.forced_value) : meas_raw;
    if (ext_comp_select) begin
      compensated = saturate(48'(compensated) + 48'(signed'(st.junction_temperature)));
    end
    unique case (st.correction_mode)
      input2_bank_pkg::CORR_OFFSET:
        corrected = saturate(48'(compensated) + 48'(signed'(st.lower_display_point))
                             - 48'(signed'(st.lower_input_point)));
      input2_bank_pkg::CORR_TWO_POINT, input2_bank_pkg::CORR_SCALING:
        corrected = line_map(compensated, st.lower_input_point, st.lower_display_point,
                             st.upper_input_point, st.upper_display_point);
      default: corrected = compensated;
    endcase
    if (sample_valid) begin
      next_st.raw_value = meas_raw;
      next_st.fault_code = {13'h0000, fault_in};
      next_st.stage = corrected;
      next_st.stage_valid = 1'b1;
    end
    // a forced value is a healthy measurement, so the fault only bites when not forcing
    if (filt_valid) begin
      next_st.processed_valid = 1'b1;
      if (st.fault_code[2:0] != input2_bank_pkg::FAULT_NONE && !force_enable) begin
        next_st.processed_value = st.fault_substitute;
      end else begin
        next_st.processed_value = filt_value;
      end
    end

    // limit alarm
    unique case (st.limit1_source)
      input2_bank_pkg::SRC_PROCESS: source = process_value;
      input2_bank_pkg::SRC_DEVIATION, input2_bank_pkg::SRC_REL_DEVIATION: source = control_deviation;
      input2_bank_pkg::SRC_INPUT1: source = input1_value;
      input2_bank_pkg::SRC_INPUT2: source = signed'(st.processed_value);
      input2_bank_pkg::SRC_SETPOINT: source = effective_setpoint;
      input2_bank_pkg::SRC_OUTPUT: source = controller_output;
      default: source = process_value;
    endcase
    exceed = (source < limit_low) || (source > limit_high);
    if (st.limit1_source == input2_bank_pkg::SRC_REL_DEVIATION && suppress_relative) begin
      exceed = 1'b0;
    end
    clear = error_list_clear || error_reset_input;
    active = 1'b0;
    unique case (st.limit1_function)
      input2_bank_pkg::LIM_MONITOR: begin
        active = exceed;
        next_st.limit_latch = 1'b0;
      end
      input2_bank_pkg::LIM_LATCH: begin
        active = exceed;
        // a new exceedance wins over a clear in the same cycle
        next_st.limit_latch = exceed || (st.limit_latch && !clear);
      end
      default: next_st.limit_latch = 1'b0;
    endcase
    next_st.limit_alarm = active || next_st.limit_latch;
    next_st.limit_status = active ? input2_bank_pkg::LSTAT_EXCEEDED :
                           next_st.limit_latch ? input2_bank_pkg::LSTAT_LATCHED : input2_bank_pkg::LSTAT_NONE;

    // heating current supervision
    unique case (st.heat_current_alarm_select)
      input2_bank_pkg::HC_BREAK: next_st.heat_alarm = heat_break;
      input2_bank_pkg::HC_BREAK_SHORT: next_st.heat_alarm = heat_break || heat_short;
      default: next_st.heat_alarm = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------
  // filter and outputs
  // --------------------------------------------------------------
  input_lowpass #(.SAMPLES_PER_SECOND(SAMPLES_PER_SECOND)) lowpass (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(st.stage_valid),
    .in_value(st.stage),
    .time_constant(st.filter_time_constant),
    .out_valid(filt_valid),
    .out_value(filt_value)
  );

  assign reg_rdata = st.rdata;
  assign reg_ack = st.ack;
  assign input2_value = st.processed_value;
  assign input2_valid = st.processed_valid;
  assign limit_alarm = st.limit_alarm;
  assign limit_status = st.limit_status;
  assign heat_alarm = st.heat_alarm;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_raw_capture: assert property (sample_valid |=> st.raw_value == $past(meas_raw))
    else $error("raw value not captured");
  a_fault_capture: assert property (sample_valid |=> st.fault_code[2:0] == $past(fault_in))
    else $error("fault code not captured");
  a_ro_write_kept: assert property (reg_write && reg_addr == input2_bank_pkg::OFS_PROCESSED_VALUE && !filt_valid
    |=> st.processed_value == $past(st.processed_value))
    else $error("read-only word changed by a write");
  a_substitute_used: assert property (filt_valid && st.fault_code[2:0] != input2_bank_pkg::FAULT_NONE
    && !force_enable |=> input2_value == $past(st.fault_substitute))
    else $error("substitute not used on fault");
  a_force_path: assert property (sample_valid && force_enable && !ext_comp_select
    && st.correction_mode == input2_bank_pkg::CORR_NONE |=> st.stage == $past(st.forced_value))
    else $error("forced value not taken as measurement");
  a_limit_disabled: assert property (st.limit1_function == input2_bank_pkg::LIM_OFF |=> !limit_alarm)
    else $error("alarm raised while disabled");
  a_latch_holds: assert property (st.limit_latch && st.limit1_function == input2_bank_pkg::LIM_LATCH
    && !error_list_clear && !error_reset_input |=> st.limit_latch && limit_alarm)
    else $error("latched alarm dropped without a clear");
  a_relative_suppress: assert property (st.limit1_function == input2_bank_pkg::LIM_MONITOR && suppress_relative
    && st.limit1_source == input2_bank_pkg::SRC_REL_DEVIATION |=> !limit_alarm)
    else $error("relative alarm not suppressed");
  a_heat_none: assert property (st.heat_current_alarm_select == input2_bank_pkg::HC_NONE |=> !heat_alarm)
    else $error("heat alarm while deselected");
  a_sample_latency: assert property (sample_valid |-> ##3 input2_valid)
    else $error("processed value not ready three cycles after a sample");

  c_latched_alarm: cover property (st.limit_latch && limit_status == input2_bank_pkg::LSTAT_LATCHED);
  c_substitute: cover property (filt_valid && st.fault_code[2:0] != input2_bank_pkg::FAULT_NONE);
  c_forced_sample: cover property (sample_valid && force_enable);
  c_heat_alarm: cover property (heat_alarm);
endmodule

// ===== input2_bank_pkg.sv
// constants for the input-two parameter bank and first limit alarm
package input2_bank_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int FAULT_W = 3;
  localparam int FRAC_BITS = 8;

  // --------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------
  localparam logic [15:0] OFS_CORRECTION_MODE = 16'h010b;
  localparam logic [15:0] OFS_LOWER_INPUT_POINT = 16'h0226;
  localparam logic [15:0] OFS_LOWER_DISPLAY_POINT = 16'h0227;
  localparam logic [15:0] OFS_UPPER_INPUT_POINT = 16'h0228;
  localparam logic [15:0] OFS_UPPER_DISPLAY_POINT = 16'h0229;
  localparam logic [15:0] OFS_FILTER_TIME = 16'h022a;
  localparam logic [15:0] OFS_JUNCTION_TEMPERATURE = 16'h022c;
  localparam logic [15:0] OFS_FAULT_SUBSTITUTE = 16'h023c;
  localparam logic [15:0] OFS_PROCESSED_VALUE = 16'h024e;
  localparam logic [15:0] OFS_FAULT_CODE = 16'h024f;
  localparam logic [15:0] OFS_RAW_VALUE = 16'h0250;
  localparam logic [15:0] OFS_FORCED_VALUE = 16'h0251;
  localparam logic [15:0] OFS_HEAT_CURRENT_ALARM = 16'h026c;
  localparam logic [15:0] OFS_LIMIT1_FUNCTION = 16'h029e;
  localparam logic [15:0] OFS_LIMIT1_SOURCE = 16'h02a0;

  localparam logic [15:0] RESET_VALUE = 16'h0000;

  // --------------------------------------------------------------
  // codes
  // --------------------------------------------------------------
  localparam logic [15:0] CORR_NONE = 16'h0000;
  localparam logic [15:0] CORR_OFFSET = 16'h0001;
  localparam logic [15:0] CORR_TWO_POINT = 16'h0002;
  localparam logic [15:0] CORR_SCALING = 16'h0003;

  localparam logic [2:0] FAULT_NONE = 3'h0;

  localparam logic [15:0] LIM_OFF = 16'h0000;
  localparam logic [15:0] LIM_MONITOR = 16'h0001;
  localparam logic [15:0] LIM_LATCH = 16'h0002;

  localparam logic [15:0] SRC_PROCESS = 16'h0000;
  localparam logic [15:0] SRC_DEVIATION = 16'h0001;
  localparam logic [15:0] SRC_REL_DEVIATION = 16'h0002;
  localparam logic [15:0] SRC_INPUT1 = 16'h0003;
  localparam logic [15:0] SRC_INPUT2 = 16'h0004;
  localparam logic [15:0] SRC_SETPOINT = 16'h0006;
  localparam logic [15:0] SRC_OUTPUT = 16'h0007;

  localparam logic [15:0] HC_NONE = 16'h0000;
  localparam logic [15:0] HC_BREAK = 16'h0001;
  localparam logic [15:0] HC_BREAK_SHORT = 16'h0002;

  localparam logic [1:0] LSTAT_NONE = 2'h0;
  localparam logic [1:0] LSTAT_LATCHED = 2'h1;
  localparam logic [1:0] LSTAT_EXCEEDED = 2'h2;

  localparam int SAMPLES_PER_SECOND = 10;
endpackage

// ===== input_lowpass.sv
// first-order low-pass filter for the input-two measurement
`timescale 1ns/1ns
module input_lowpass #(
  parameter int SAMPLES_PER_SECOND = input2_bank_pkg::SAMPLES_PER_SECOND
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic signed [15:0] in_value,
  input wire logic [15:0] time_constant,
  output logic out_valid,
  output logic signed [15:0] out_value
);
  typedef struct packed {
    logic signed [31:0] acc;
    logic valid;
  } filt_state_t;

  filt_state_t st;
  filt_state_t next_st;
  logic signed [31:0] target;
  logic signed [31:0] divisor;

  // --------------------------------------------------------------
  // filter step
  // --------------------------------------------------------------
  // a divider per step is costly but the sample rate is low
  always_comb begin
    next_st = st;
    next_st.valid = 1'b0;
    target = {{(16 - input2_bank_pkg::FRAC_BITS){in_value[15]}}, in_value, {input2_bank_pkg::FRAC_BITS{1'b0}}};
    divisor = 32'(signed'({16'h0000, time_constant}) * SAMPLES_PER_SECOND + 1);
    if (in_valid) begin
      next_st.valid = 1'b1;
      if (time_constant == 16'h0000) begin
        next_st.acc = target;
      end else begin
        next_st.acc = st.acc + (target - st.acc) / divisor;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_valid = st.valid;
  assign out_value = st.acc[15 + input2_bank_pkg::FRAC_BITS:input2_bank_pkg::FRAC_BITS];

  a_filter_bypass: assert property (@(posedge clock) disable iff (!rst_n)
    in_valid && time_constant == 16'h0000 |=> out_value == $past(in_value))
    else $error("zero time constant did not pass the sample through");
endmodule

// ===== fieldbus_master.sv
// fieldbus master model issuing single-word register accesses
`timescale 1ns/1ns
module fieldbus_master (
  input wire logic clock,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_write,
  output logic reg_read
);
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // one strobe cycle per word; released lines are inverted so stale values never look valid
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    #10;
    reg_addr = a;
    reg_wdata = d;
    reg_write = w;
    reg_read = !w;
    @(posedge clock);
    #10;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule

// ===== test_input2_param_bank.sv
// self-checking testbench of the input-two parameter bank
`timescale 1ns/1ns
module test_input2_param_bank;
  logic clock, rst_n, reg_write, reg_read, reg_ack, sample_valid, ext_comp_select, force_enable;
  logic suppress_relative, error_list_clear, error_reset_input, heat_break, heat_short;
  logic input2_valid, limit_alarm, heat_alarm;
  logic [1:0] limit_status;
  logic [2:0] fault_in;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic signed [15:0] meas_raw, process_value, control_deviation, input1_value, effective_setpoint;
  logic signed [15:0] controller_output, limit_low, limit_high, input2_value;
  logic [16:0] bus_q[$];
  logic [15:0] val_q[$];
  logic [31:0] lfsr = 32'hbf83;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  localparam logic [15:0] ALL_OFS [15] = '{input2_bank_pkg::OFS_CORRECTION_MODE,
    input2_bank_pkg::OFS_LOWER_INPUT_POINT, input2_bank_pkg::OFS_LOWER_DISPLAY_POINT,
    input2_bank_pkg::OFS_UPPER_INPUT_POINT, input2_bank_pkg::OFS_UPPER_DISPLAY_POINT,
    input2_bank_pkg::OFS_FILTER_TIME, input2_bank_pkg::OFS_JUNCTION_TEMPERATURE,
    input2_bank_pkg::OFS_FAULT_SUBSTITUTE, input2_bank_pkg::OFS_FORCED_VALUE,
    input2_bank_pkg::OFS_HEAT_CURRENT_ALARM, input2_bank_pkg::OFS_LIMIT1_FUNCTION,
    input2_bank_pkg::OFS_LIMIT1_SOURCE, input2_bank_pkg::OFS_PROCESSED_VALUE,
    input2_bank_pkg::OFS_FAULT_CODE, input2_bank_pkg::OFS_RAW_VALUE};
  localparam logic [15:0] CORR_EXP [4] = '{16'h003c, 16'h0050, 16'h0082, 16'h0082};
  localparam logic [15:0] SRC_CODE [5] = '{16'h0000, 16'h0001, 16'h0003, 16'h0006, 16'h0007};

  // ----------------------------------------------------------------
  // design, master and clock
  // ----------------------------------------------------------------
  input2_param_bank #(.SAMPLES_PER_SECOND(1)) u_dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .reg_ack, .sample_valid, .meas_raw, .fault_in, .ext_comp_select, .force_enable,
    .process_value, .control_deviation, .input1_value, .effective_setpoint, .controller_output,
    .suppress_relative, .limit_low, .limit_high, .error_list_clear, .error_reset_input, .heat_break,
    .heat_short, .input2_value, .input2_valid, .limit_alarm, .limit_status, .heat_alarm);
  fieldbus_master u_master (.clock, .reg_addr, .reg_wdata, .reg_write, .reg_read);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // checking and notes
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic conclude();
    if (fails == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    bus_q.push_back(17'h00000);
    u_master.access(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    bus_q.push_back({1'b1, e});
    u_master.access(1'b0, a, 16'h0000);
  endtask
  // the pipeline is three edges deep; waiting four keeps register reads after the update
  task automatic sample(input logic [15:0] x, input logic [2:0] f, input logic [15:0] e);
    val_q.push_back(e);
    @(posedge clock);
    #10;
    meas_raw = x;
    fault_in = f;
    sample_valid = 1'b1;
    @(posedge clock);
    #10;
    sample_valid = 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic settle(input logic a, input logic [1:0] s);
    repeat (3) @(posedge clock);
    #10;
    check("limit_alarm", limit_alarm, a);
    check("limit_status", limit_status, s);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
    if (reg_ack === 1'b1) begin
      check("bus_note", bus_q.size() != 0, 16'h0001);
      if (bus_q.size() != 0 && bus_q[0][16]) check("reg_rdata", reg_rdata, bus_q[0][15:0]);
      if (bus_q.size() != 0) void'(bus_q.pop_front());
    end
    if (input2_valid === 1'b1) begin
      check("value_note", val_q.size() != 0, 16'h0001);
      if (val_q.size() != 0) check("input2_value", input2_value, val_q.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] r;
    rst_n = 1'b0;
    {sample_valid, ext_comp_select, force_enable, suppress_relative} = 4'h0;
    {error_list_clear, error_reset_input, heat_break, heat_short, fault_in} = 7'h00;
    {meas_raw, process_value, control_deviation, input1_value, effective_setpoint, controller_output} = '0;
    limit_low = -16'sd10;
    limit_high = 16'sd10;
    repeat (3) @(posedge clock);
    #10;
    rst_n = 1'b1;
    for (int i = 0; i < 15; i++) rd(ALL_OFS[i], 16'h0000);
    wr(16'h0300, 16'h5a5a);
    rd(16'h0300, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_step(lfsr);
      wr(ALL_OFS[i], lfsr[15:0]);
      rd(ALL_OFS[i], lfsr[15:0]);
      wr(ALL_OFS[i], 16'h0000);
    end
    lfsr = lfsr_step(lfsr);
    r = {{5{lfsr[10]}}, lfsr[10:0]};
    sample(r, 3'h0, r);
    rd(input2_bank_pkg::OFS_RAW_VALUE, r);
    for (int i = 12; i < 15; i++) wr(ALL_OFS[i], ~r);
    rd(input2_bank_pkg::OFS_RAW_VALUE, r);
    rd(input2_bank_pkg::OFS_PROCESSED_VALUE, r);
    rd(input2_bank_pkg::OFS_FAULT_CODE, 16'h0000);
    wr(input2_bank_pkg::OFS_LOWER_INPUT_POINT, 16'h000a);
    wr(input2_bank_pkg::OFS_LOWER_DISPLAY_POINT, 16'h001e);
    wr(input2_bank_pkg::OFS_UPPER_INPUT_POINT, 16'h006e);
    wr(input2_bank_pkg::OFS_UPPER_DISPLAY_POINT, 16'h00e6);
    for (int c = 0; c < 4; c++) begin
      wr(input2_bank_pkg::OFS_CORRECTION_MODE, c[15:0]);
      sample(16'h003c, 3'h0, CORR_EXP[c]);
    end
    sample(16'h000a, 3'h0, 16'h001e);
    sample(16'h006e, 3'h0, 16'h00e6);
    wr(input2_bank_pkg::OFS_CORRECTION_MODE, input2_bank_pkg::CORR_NONE);
    wr(input2_bank_pkg::OFS_FAULT_SUBSTITUTE, 16'h0077);
    for (int f = 1; f <= 4; f = f * 2) begin
      sample(16'h0005, f[2:0], 16'h0077);
      rd(input2_bank_pkg::OFS_FAULT_CODE, f[15:0]);
    end
    wr(input2_bank_pkg::OFS_FORCED_VALUE, 16'h0123);
    force_enable = 1'b1;
    sample(16'h0005, 3'h1, 16'h0123);
    force_enable = 1'b0;
    wr(input2_bank_pkg::OFS_JUNCTION_TEMPERATURE, 16'h0005);
    ext_comp_select = 1'b1;
    sample(16'h000a, 3'h0, 16'h000f);
    ext_comp_select = 1'b0;
    sample(16'h0000, 3'h0, 16'h0000);
    wr(input2_bank_pkg::OFS_FILTER_TIME, 16'h0001);
    sample(16'h0064, 3'h0, 16'h0032);
    sample(16'h0064, 3'h0, 16'h004b);
    wr(input2_bank_pkg::OFS_LIMIT1_FUNCTION, input2_bank_pkg::LIM_MONITOR);
    for (int i = 0; i < 5; i++) begin
      {process_value, control_deviation, input1_value, effective_setpoint, controller_output} = '0;
      case (i)
        0: process_value = 16'sd50;
        1: control_deviation = 16'sd50;
        2: input1_value = 16'sd50;
        3: effective_setpoint = 16'sd50;
        default: controller_output = 16'sd50;
      endcase
      wr(input2_bank_pkg::OFS_LIMIT1_SOURCE, SRC_CODE[i]);
      settle(1'b1, 2'h2);
    end
    controller_output = 16'sd0;
    control_deviation = 16'sd50;
    suppress_relative = 1'b1;
    wr(input2_bank_pkg::OFS_LIMIT1_SOURCE, input2_bank_pkg::SRC_REL_DEVIATION);
    settle(1'b0, 2'h0);
    suppress_relative = 1'b0;
    settle(1'b1, 2'h2);
    control_deviation = 16'sd0;
    settle(1'b0, 2'h0);
    wr(input2_bank_pkg::OFS_LIMIT1_SOURCE, input2_bank_pkg::SRC_PROCESS);
    wr(input2_bank_pkg::OFS_LIMIT1_FUNCTION, input2_bank_pkg::LIM_LATCH);
    for (int j = 0; j < 2; j++) begin
      process_value = 16'sd50;
      settle(1'b1, 2'h2);
      process_value = 16'sd0;
      settle(1'b1, 2'h1);
      {error_list_clear, error_reset_input} = j[0] ? 2'h2 : 2'h1;
      settle(1'b0, 2'h0);
      {error_list_clear, error_reset_input} = 2'h0;
    end
    wr(input2_bank_pkg::OFS_LIMIT1_FUNCTION, input2_bank_pkg::LIM_OFF);
    process_value = 16'sd50;
    settle(1'b0, 2'h0);
    for (int h = 0; h < 3; h++) begin
      wr(input2_bank_pkg::OFS_HEAT_CURRENT_ALARM, h[15:0]);
      for (int b = 1; b < 3; b++) begin
        {heat_break, heat_short} = b[1:0];
        repeat (3) @(posedge clock);
        #10;
        check("heat_alarm", heat_alarm, (h == 2) || (h == 1 && b == 2));
      end
    end
    repeat (4) @(posedge clock);
    conclude();
  end
endmodule
